//--- include/pmicps_pkg.sv
// package of constants, types and helpers for the power state machine
package pmicps_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int CLK_MHZ = CLK_HZ / 1000000;
  localparam int WDR_DELAY_NS = 30000;
  // least time, rounded up to whole cycles
  localparam int WDR_DELAY_CYC = (WDR_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int SHDN_TIME_US = 500;
  localparam int SHDN_CYC_DFLT = SHDN_TIME_US * CLK_MHZ;
  localparam int STEST_GAP_US = 2000;
  localparam int STEST_GAP_CYC_DFLT = STEST_GAP_US * CLK_MHZ;
  localparam logic [1:0] STEST_MAX_FAILS = 2'h3;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LIMITS = 8'h04;
  localparam logic [7:0] REG_KEYHOLD = 8'h08;
  localparam logic [7:0] REG_OVDBNC = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // control fields
  localparam int CTRL_POLINV = 0;
  localparam int CTRL_QWAKE = 1;
  localparam int CTRL_EDGE = 2;
  localparam int CTRL_OVSDWN = 3;
  localparam int CTRL_SHDN = 4;
  localparam int CTRL_FSBYP = 5;
  localparam int CTRL_OVDIS = 6;
  // limit fields
  localparam int LIM_WDOG = 0;
  localparam int LIM_FAULT = 4;
  localparam int LIM_FS = 8;
  // status fields
  localparam int STAT_STATE = 0;
  localparam int STAT_WDCNT = 4;
  localparam int STAT_FSCNT = 8;
  localparam int STAT_STFAIL = 12;
  localparam int STAT_STERR = 14;
  localparam int STAT_HOSTRST = 16;
  // reset values and bus response codes
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LIMITS_RST = 32'h0000_0333;
  localparam logic [31:0] KEYHOLD_RST = 32'h0000_0FA0;
  localparam logic [31:0] OVDBNC_RST = 32'h0000_00FA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    ST_DEEP_OFF = 4'h0,
    ST_SELFTEST = 4'h1,
    ST_READY_OFF = 4'h2,
    ST_POWER_UP = 4'h3,
    ST_RUN = 4'h4,
    ST_STANDBY = 4'h5,
    ST_WD_RESET = 4'h6,
    ST_PD_REQ = 4'h7,
    ST_PD_FAULT = 4'h8,
    ST_FS_TRANS = 4'h9,
    ST_FS_LOCK = 4'hA
  } pmicps_state_t;

  // asynchronous pins and analog comparators
  typedef struct packed {
    logic powerKeyIn;
    logic lowPowerIn;
    logic trialConfigPin;
    logic vinAboveUv;
    logic vinAboveOv;
    logic tjOverTsd;
  } pmicps_pins_t;

  // answers from the regulator sequencer
  typedef struct packed {
    logic upResetRelease;
    logic upFail;
    logic downDone;
  } pmicps_seq_in_t;

  // requests to the regulator sequencer
  typedef struct packed {
    logic upRun;
    logic downRun;
    logic downFault;
  } pmicps_seq_out_t;

  // ==========================================================================
  // power-up qualification: supply in window, die cool, no load errors
  function automatic logic pmicps_qual(pmicps_pins_t p, logic ovDis, logic errs);
    return p.vinAboveUv && (!p.vinAboveOv || ovDis) && !p.tjOverTsd && !errs;
  endfunction

  // key event of the selected mode: high level, or a high-to-low edge
  function automatic logic pmicps_key(logic edgeMode, logic level, logic prev);
    return edgeMode ? (prev && !level) : level;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] pmicps_merge(logic [31:0] old, logic [31:0] d,
                                               logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (d & m);
  endfunction

endpackage

//--- rtl/pmicps_sync.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/100ps
module pmicps_sync
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [5:0] d,
  output logic [5:0] q
);
  import pmicps_pkg::*;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] q;
  } pmicps_sync_st_t;

  pmicps_sync_st_t r;
  pmicps_sync_st_t next_r;

  // ==========================================================================
  // shift chain; a bit changes only once stages two and three agree
  always_comb
  begin
    next_r = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q = (r.s2 & r.s3) | (r.q & (r.s2 ^ r.s3));
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      r <= '0;
    else
      r <= next_r;
  end

  assign q = r.q;
endmodule // pmicps_sync

//--- rtl/pmicps_timer.sv
// one-shot down-counting timer with an expiry pulse
`timescale 1ns/100ps
module pmicps_timer
(
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic [15:0] loadValue,
  output logic expired
);
  import pmicps_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic busy;
    logic expired;
  } pmicps_timer_st_t;

  pmicps_timer_st_t r;
  pmicps_timer_st_t next_r;

  // ==========================================================================
  // a new start restarts the count, so a retrigger never leaves a stale pulse
  always_comb
  begin
    next_r = r;
    next_r.expired = 1'b0;
    if (start)
    begin
      next_r.cnt = loadValue;
      next_r.busy = 1'b1;
    end
    else if (r.busy)
    begin
      if (r.cnt <= 16'h0001)
      begin
        next_r.busy = 1'b0;
        next_r.expired = 1'b1;
      end
      else
        next_r.cnt = r.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      r <= '0;
    else
      r <= next_r;
  end

  assign expired = r.expired;
endmodule // pmicps_timer

//--- rtl/pmicps_top.sv
// top-level power state machine with its register slave
// Overview of operation
// - standby returns to run on inactive input
// - run enters standby on active input
// - hard watchdog event enters watchdog reset
// - after 30 us, below limit, back on
// - watchdog count at limit: fault power-down
// - quick-wake leaves deep off unprompted
// - level mode: key high powers up
// - edge mode: key falling powers up
// - trial pin high reaches ready off
// - self-test pass or trial pin: ready off
// - requested power-up passes through ready off
// - quick-wake: ready off waits for key
// - trial pin: key event powers up too
// - host reset release enters system on
// - level mode: key low turns off
// - edge mode: key held low turns off
// - soft shutdown bit turns off after 500us
// - persistent overvoltage gives protective power-down
// - fault timer, count or heat: fault down
// - requested power-down ends in deep off
// - power-up failure aborts to fault down
// - three self-test fails go fail-safe
// - fault power-down ends in fail-safe transition
// - fail-safe below limit or bypassed: deep off
// - fail-safe count at limit locks
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module pmicps_top
#(
  parameter int SHDN_CYC = pmicps_pkg::SHDN_CYC_DFLT,
  parameter int STEST_GAP_CYC = pmicps_pkg::STEST_GAP_CYC_DFLT,
  parameter bit SAFETY_VARIANT = 1'b1
)
(
  input wire logic clock,
  input wire logic srst,
  input pmicps_pkg::pmicps_pins_t pinsIn,
  input wire logic trimLoadError,
  input wire logic fuseLoadError,
  input wire logic wdogHardReset,
  input wire logic faultTimerExpired,
  input wire logic [3:0] faultEventCount,
  input wire logic selftestDone,
  input wire logic selftestPass,
  output logic selftestStart,
  input pmicps_pkg::pmicps_seq_in_t seqIn,
  output pmicps_pkg::pmicps_seq_out_t seqOut,
  output logic hostResetN,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pmicps_pkg::*;

  typedef struct packed {
    pmicps_state_t state;
    logic upReq;
    logic [3:0] wdCnt;
    logic [3:0] fsCnt;
    logic [1:0] stFails;
    logic stErr;
    logic stStart;
    logic keyPrev;
    logic holdArm;
    logic [15:0] holdCnt;
    logic [15:0] ovCnt;
    logic hostRstN;
    logic [31:0] ctrl;
    logic [31:0] limits;
    logic [31:0] keyHold;
    logic [31:0] ovDbnc;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } pmicps_top_st_t;

  pmicps_top_st_t r;
  pmicps_top_st_t next_r;
  pmicps_pins_t pins;
  logic wdTimerDone;
  logic shdnTimerDone;
  logic gapTimerDone;
  logic wdTimerStart;
  logic shdnTimerStart;
  logic gapTimerStart;
  logic sysOn;
  logic lpActive;
  logic keyEvt;
  logic errsOff;
  logic qualOk;
  logic faultOff;
  logic reqOff;
  logic [3:0] wdLimit;
  logic [3:0] faultLimit;
  logic [3:0] fsLimit;

  // ==========================================================================
  // pins and timers
  pmicps_sync u_sync (
    .clock(clock),
    .srst(srst),
    .d(pinsIn),
    .q(pins)
  );

  pmicps_timer u_wd_timer (
    .clock(clock),
    .srst(srst),
    .start(wdTimerStart),
    .loadValue(16'(WDR_DELAY_CYC)),
    .expired(wdTimerDone)
  );

  pmicps_timer u_shdn_timer (
    .clock(clock),
    .srst(srst),
    .start(shdnTimerStart),
    .loadValue(16'(SHDN_CYC)),
    .expired(shdnTimerDone)
  );

  pmicps_timer u_gap_timer (
    .clock(clock),
    .srst(srst),
    .start(gapTimerStart),
    .loadValue(16'(STEST_GAP_CYC)),
    .expired(gapTimerDone)
  );

  // ==========================================================================
  // decoded conditions
  assign wdLimit = r.limits[LIM_WDOG +: 4];
  assign faultLimit = r.limits[LIM_FAULT +: 4];
  assign fsLimit = r.limits[LIM_FS +: 4];
  assign sysOn = (r.state == ST_RUN) || (r.state == ST_STANDBY);
  // standby input after its polarity bit
  assign lpActive = pins.lowPowerIn ^ r.ctrl[CTRL_POLINV];
  assign keyEvt = pmicps_key(r.ctrl[CTRL_EDGE], pins.powerKeyIn, r.keyPrev);
  assign errsOff = trimLoadError || fuseLoadError;
  assign qualOk = pmicps_qual(pins, r.ctrl[CTRL_OVDIS], errsOff);
  // heat, fault timer or fault count all end in the fault path
  assign faultOff = faultTimerExpired || (faultEventCount == faultLimit) || pins.tjOverTsd;
  // the soft timer is only watched while the machine is on
  assign reqOff = (!r.ctrl[CTRL_EDGE] && !pins.powerKeyIn)
    || (r.holdArm && !pins.powerKeyIn && (r.holdCnt > r.keyHold[15:0]))
    || shdnTimerDone
    || (r.ctrl[CTRL_OVSDWN] && (r.ovCnt > r.ovDbnc[15:0]));
  assign wdTimerStart = (next_r.state == ST_WD_RESET) && (r.state != ST_WD_RESET);
  assign shdnTimerStart = next_r.ctrl[CTRL_SHDN] && !r.ctrl[CTRL_SHDN];
  assign gapTimerStart = (r.state == ST_SELFTEST) && selftestDone && !selftestPass
    && (next_r.state == ST_SELFTEST);

  // ==========================================================================
  // next state: machine, counters and register slave
  always_comb
  begin
    next_r = r;
    next_r.keyPrev = pins.powerKeyIn;
    next_r.stStart = 1'b0;
    // power-key hold timer for edge-mode turn-off
    if (sysOn && r.ctrl[CTRL_EDGE] && r.keyPrev && !pins.powerKeyIn)
    begin
      next_r.holdArm = 1'b1;
      next_r.holdCnt = '0;
    end
    else if (!sysOn || pins.powerKeyIn)
      next_r.holdArm = 1'b0;
    else if (r.holdArm && r.holdCnt != 16'hFFFF)
      next_r.holdCnt = r.holdCnt + 16'h0001;
    // overvoltage persistence, saturating
    if (sysOn && pins.vinAboveOv)
    begin
      if (r.ovCnt != 16'hFFFF)
        next_r.ovCnt = r.ovCnt + 16'h0001;
    end
    else
      next_r.ovCnt = '0;
    case (r.state)
      ST_DEEP_OFF:
      begin
        next_r.upReq = 1'b0;
        if (pins.trialConfigPin || r.ctrl[CTRL_QWAKE])
          next_r.state = SAFETY_VARIANT ? ST_SELFTEST : ST_READY_OFF;
        else if (keyEvt && qualOk)
        begin
          next_r.upReq = 1'b1;
          next_r.state = SAFETY_VARIANT ? ST_SELFTEST : ST_READY_OFF;
        end
        if (SAFETY_VARIANT && next_r.state == ST_SELFTEST)
        begin
          next_r.stStart = 1'b1;
          next_r.stFails = '0;
        end
      end
      ST_SELFTEST:
      begin
        if (pins.trialConfigPin)
          next_r.state = ST_READY_OFF;
        else if (selftestDone && selftestPass)
        begin
          next_r.stErr = 1'b0;
          next_r.state = ST_READY_OFF;
        end
        else if (selftestDone)
        begin
          next_r.stErr = 1'b1;
          next_r.stFails = r.stFails + 2'h1;
          if (next_r.stFails == STEST_MAX_FAILS)
            next_r.state = ST_FS_TRANS;
        end
        else if (gapTimerDone)
          next_r.stStart = 1'b1;
      end
      ST_READY_OFF:
      begin
        if (r.upReq && !r.ctrl[CTRL_QWAKE] && !pins.trialConfigPin)
        begin
          // with an error the request is dropped, the machine stays in ready off one more cycle and then falls back to deep off
          next_r.upReq = 1'b0;
          if (!errsOff && !r.stErr)
            next_r.state = ST_POWER_UP;
        end
        else if ((r.ctrl[CTRL_QWAKE] || pins.trialConfigPin) && keyEvt && qualOk && !r.stErr)
          next_r.state = ST_POWER_UP;
        else if (!r.ctrl[CTRL_QWAKE] && !pins.trialConfigPin)
          next_r.state = ST_DEEP_OFF;
      end
      ST_POWER_UP:
      begin
        if (seqIn.upFail)
          next_r.state = ST_PD_FAULT;
        else if (seqIn.upResetRelease)
          next_r.state = ST_RUN;
      end
      ST_RUN, ST_STANDBY:
      begin
        if (faultOff)
          next_r.state = ST_PD_FAULT;
        else if (wdogHardReset)
        begin
          next_r.state = ST_WD_RESET;
          next_r.wdCnt = r.wdCnt + 4'h1;
        end
        else if (reqOff)
          next_r.state = ST_PD_REQ;
        else if (r.state == ST_RUN && lpActive)
          next_r.state = ST_STANDBY;
        else if (r.state == ST_STANDBY && !lpActive)
          next_r.state = ST_RUN;
      end
      ST_WD_RESET:
      begin
        if (r.wdCnt == wdLimit)
          next_r.state = ST_PD_FAULT;
        else if (wdTimerDone && r.wdCnt < wdLimit)
          next_r.state = ST_RUN;
      end
      ST_PD_REQ:
      begin
        if (seqIn.downDone)
          next_r.state = ST_DEEP_OFF;
      end
      ST_PD_FAULT:
      begin
        if (seqIn.downDone)
        begin
          next_r.state = SAFETY_VARIANT ? ST_FS_TRANS : ST_DEEP_OFF;
          next_r.fsCnt = SAFETY_VARIANT ? r.fsCnt + 4'h1 : r.fsCnt;
        end
      end
      ST_FS_TRANS:
      begin
        if (r.fsCnt < fsLimit || r.ctrl[CTRL_FSBYP])
          next_r.state = ST_DEEP_OFF;
        else
          next_r.state = ST_FS_LOCK;
      end
      ST_FS_LOCK:
        next_r.state = ST_FS_LOCK;
      default:
        next_r.state = ST_DEEP_OFF;
    endcase
    // the watchdog count starts over on a requested power-down into deep off
    if (next_r.state == ST_DEEP_OFF && r.state == ST_PD_REQ)
      next_r.wdCnt = '0;
    next_r.hostRstN = (next_r.state == ST_RUN) || (next_r.state == ST_STANDBY);
    // soft shutdown bit is spent once the machine heads into requested power-down
    if (next_r.state == ST_PD_REQ)
      next_r.ctrl[CTRL_SHDN] = 1'b0;
    // write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.awHeld = 1'b1;
      next_r.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.wHeld = 1'b1;
      next_r.wData = s_axi_wdata;
      next_r.wStrb = s_axi_wstrb;
    end
    if (r.awHeld && r.wHeld)
    begin
      next_r.awHeld = 1'b0;
      next_r.wHeld = 1'b0;
      next_r.bValid = 1'b1;
      next_r.bResp = RESP_OKAY;
      case ({r.awAddr[7:2], 2'b00})
        REG_CTRL: next_r.ctrl = pmicps_merge(next_r.ctrl, r.wData, r.wStrb);
        REG_LIMITS: next_r.limits = pmicps_merge(r.limits, r.wData, r.wStrb);
        REG_KEYHOLD: next_r.keyHold = pmicps_merge(r.keyHold, r.wData, r.wStrb);
        REG_OVDBNC: next_r.ovDbnc = pmicps_merge(r.ovDbnc, r.wData, r.wStrb);
        REG_STATUS: next_r.bResp = RESP_OKAY;
        default: next_r.bResp = RESP_SLVERR;
      endcase
    end
    else if (r.bValid && s_axi_bready)
      next_r.bValid = 1'b0;
    // read channel, one cycle to data
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_r.rValid = 1'b1;
      next_r.rResp = RESP_OKAY;
      next_r.rData = '0;
      case ({s_axi_araddr[7:2], 2'b00})
        REG_CTRL: next_r.rData = r.ctrl;
        REG_LIMITS: next_r.rData = r.limits;
        REG_KEYHOLD: next_r.rData = r.keyHold;
        REG_OVDBNC: next_r.rData = r.ovDbnc;
        REG_STATUS:
        begin
          next_r.rData[STAT_STATE +: 4] = r.state;
          next_r.rData[STAT_WDCNT +: 4] = r.wdCnt;
          next_r.rData[STAT_FSCNT +: 4] = r.fsCnt;
          next_r.rData[STAT_STFAIL +: 2] = r.stFails;
          next_r.rData[STAT_STERR] = r.stErr;
          next_r.rData[STAT_HOSTRST] = r.hostRstN;
        end
        default: next_r.rResp = RESP_SLVERR;
      endcase
    end
    else if (r.rValid && s_axi_rready)
      next_r.rValid = 1'b0;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      r <= '0;
      r.state <= ST_DEEP_OFF;
      r.ctrl <= CTRL_RST;
      r.limits <= LIMITS_RST;
      r.keyHold <= KEYHOLD_RST;
      r.ovDbnc <= OVDBNC_RST;
    end
    else
      r <= next_r;
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready = !r.awHeld && !r.bValid;
  assign s_axi_wready = !r.wHeld && !r.bValid;
  assign s_axi_bvalid = r.bValid;
  assign s_axi_bresp = r.bResp;
  assign s_axi_arready = !r.rValid;
  assign s_axi_rvalid = r.rValid;
  assign s_axi_rdata = r.rData;
  assign s_axi_rresp = r.rResp;
  assign hostResetN = r.hostRstN;
  assign selftestStart = r.stStart;
  assign seqOut.upRun = (r.state == ST_POWER_UP);
  assign seqOut.downRun = (r.state == ST_PD_REQ) || (r.state == ST_PD_FAULT);
  assign seqOut.downFault = (r.state == ST_PD_FAULT);

  // ==========================================================================
  // checks
  logic [15:0] wdDwell;
  always_ff @(posedge clock)
  begin
    if (srst || r.state != ST_WD_RESET)
      wdDwell <= '0;
    else
      wdDwell <= wdDwell + 16'h0001;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  a_enter_standby: assert property (
    (r.state == ST_STANDBY && $past(r.state) == ST_RUN) |-> $past(lpActive))
    else $error("standby entered without active input");
  a_leave_standby: assert property (
    (r.state == ST_RUN && $past(r.state) == ST_STANDBY) |-> !$past(lpActive))
    else $error("run entered with standby input active");
  a_wdog_entry: assert property (
    (sysOn && !faultOff && wdogHardReset) |=> r.state == ST_WD_RESET)
    else $error("hard watchdog event ignored");
  a_wdog_delay: assert property (
    (r.state == ST_RUN && $past(r.state) == ST_WD_RESET)
    |-> $past(wdDwell) >= 16'(WDR_DELAY_CYC))
    else $error("watchdog reset left before delay");
  a_wdog_limit: assert property (
    (r.state == ST_WD_RESET && r.wdCnt == wdLimit) |=> r.state == ST_PD_FAULT)
    else $error("watchdog limit did not force fault");
  a_wdog_count: assert property (
    (r.state == ST_WD_RESET && $past(r.state) != ST_WD_RESET)
    |-> r.wdCnt == $past(r.wdCnt) + 4'h1)
    else $error("watchdog count not advanced");
  a_host_release: assert property (
    $rose(hostResetN) |-> sysOn && $past(r.state) inside {ST_POWER_UP, ST_WD_RESET})
    else $error("host released outside power-up");
  a_upfail_abort: assert property (
    (r.state == ST_POWER_UP && seqIn.upFail) |=> r.state == ST_PD_FAULT ##1 !hostResetN)
    else $error("power-up failure not aborted");
  a_fault_down: assert property (
    (sysOn && faultOff) |=> r.state == ST_PD_FAULT && !hostResetN)
    else $error("fault did not force power-down");
  a_fs_lock: assert property (
    (r.state == ST_FS_TRANS && r.fsCnt == fsLimit && !r.ctrl[CTRL_FSBYP])
    |=> r.state == ST_FS_LOCK [*2])
    else $error("fail-safe lock missed");
endmodule // pmicps_top

//--- tb/pmicps_host_model.sv
// behavioural host processor held in reset by the power state machine
`timescale 1ns/100ps
module pmicps_host_model
(
  input wire logic clock,
  input wire logic hostResetN,
  output logic booted
);
  // ==========================================================
  // boot count: restarts whenever the host is held in reset
  logic [3:0] bootCount = 4'h0;
  always_ff @(posedge clock)
  begin
    bootCount <= !hostResetN ? 4'h0 : bootCount + {3'h0, bootCount != 4'hF};
  end
  assign booted = (bootCount == 4'hF); // late flag hides brief glitches
endmodule // pmicps_host_model

//--- tb/test_pmic_power_state_machine.sv
// self-checking bench for the power state machine
`timescale 1ns/100ps
module test_pmic_power_state_machine;
  import pmicps_pkg::*;
  // ==========================================================
  // design-facing signals
  logic clock = 1'h0;
  logic srst = 1'h1;
  pmicps_pins_t pinsIn = '0;
  pmicps_seq_in_t seqIn = '0;
  pmicps_seq_out_t seqOut;
  logic trimLoadError = 1'h0, fuseLoadError = 1'h0, wdogHardReset = 1'h0;
  logic faultTimerExpired = 1'h0, selftestDone = 1'h0, selftestPass = 1'h0;
  logic [3:0] faultEventCount = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic selftestStart, hostResetN, hostUp, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdVal, seed = 32'h0000005E;
  logic [1:0] s_axi_bresp, s_axi_rresp, rspVal;
  int numErrors = 0, numChecks = 0, stStarts = 0;
  always #20 clock = ~clock;
  // self-test start pulses are too short for status polling to catch
  always @(posedge clock)
    stStarts <= stStarts + int'(selftestStart);
  pmicps_top #(.SHDN_CYC(20), .STEST_GAP_CYC(10)) u_dut
  (
    .clock, .srst, .pinsIn, .trimLoadError, .fuseLoadError, .wdogHardReset,
    .faultTimerExpired, .faultEventCount, .selftestDone, .selftestPass, .selftestStart,
    .seqIn, .seqOut, .hostResetN, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  pmicps_host_model u_host
  (
    .clock, .hostResetN, .booted(hostUp)
  );
  // ==========================================================
  // helpers: random source, bus cycle, comparison, verdict
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // readies are sampled mid-cycle, so the edge updates never race
  task automatic ax(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ar, done;
    @(posedge clock);
    aw = wr;
    w = wr;
    ar = !wr;
    done = 1'h0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= aw;
    s_axi_wvalid <= w;
    s_axi_arvalid <= ar;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    while (!done)
    begin
      @(negedge clock);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      ar = ar && !s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      rspVal = wr ? s_axi_bresp : s_axi_rresp;
      rdVal = s_axi_rdata;
      @(posedge clock);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      s_axi_arvalid <= ar;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // poll the status word until the state shows up or patience ends
  task automatic st(input logic [3:0] s);
    int n;
    n = 0;
    ax(1'h0, REG_STATUS, '0);
    while (rdVal[3:0] !== s && n < 60)
    begin
      ax(1'h0, REG_STATUS, '0);
      n++;
    end
    chk("state", {28'h0, s}, {28'h0, rdVal[3:0]});
  endtask
  // deep off to run: self-test passes, then the release step ends power-up
  task automatic pwr();
    st(ST_SELFTEST);
    selftestPass <= 1'h1;
    selftestDone <= 1'h1;
    @(posedge clock);
    selftestDone <= 1'h0;
    st(ST_POWER_UP);
    chk("uprun", 32'h1, {31'h0, seqOut.upRun});
    seqIn.upResetRelease <= 1'h1;
    @(posedge clock);
    seqIn.upResetRelease <= 1'h0;
    st(ST_RUN);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog: the whole sequence needs about 1000 cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    numErrors++;
    results();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    srst <= 1'h0;
    ax(1'h0, REG_CTRL, '0);
    chk("ctrl", CTRL_RST, rdVal);
    ax(1'h0, REG_LIMITS, '0);
    chk("limits", LIMITS_RST, rdVal);
    ax(1'h0, 8'h14, '0);
    chk("unmapped", 32'h2, {30'h0, rspVal});
    seed = xs(seed);
    ax(1'h1, REG_KEYHOLD, {16'h0, seed[15:0]});
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rspVal});
    ax(1'h0, REG_KEYHOLD, '0);
    chk("keyhold", {16'h0, seed[15:0]}, rdVal);
    $display("registers done");
    pinsIn.vinAboveUv <= 1'h1;
    pinsIn.powerKeyIn <= 1'h1;
    pwr();
    repeat (20) @(posedge clock);
    chk("hostup", 32'h1, {31'h0, hostUp});
    $display("power up done");
    pinsIn.lowPowerIn <= 1'h1;
    st(ST_STANDBY);
    pinsIn.lowPowerIn <= 1'h0;
    st(ST_RUN);
    seed = xs(seed);
    repeat (seed[3:0]) @(posedge clock);
    wdogHardReset <= 1'h1;
    @(posedge clock);
    wdogHardReset <= 1'h0;
    st(ST_WD_RESET);
    repeat (600) @(posedge clock);
    ax(1'h0, REG_STATUS, '0);
    chk("wdhold", 32'h6, {28'h0, rdVal[3:0]});
    st(ST_RUN);
    chk("wdcount", 32'h1, {28'h0, rdVal[7:4]});
    $display("standby and watchdog done");
    faultTimerExpired <= 1'h1;
    @(posedge clock);
    faultTimerExpired <= 1'h0;
    st(ST_PD_FAULT);
    chk("downfault", 32'h1, {31'h0, seqOut.downFault});
    chk("hostoff", 32'h0, {31'h0, hostResetN});
    seqIn.downDone <= 1'h1;
    @(posedge clock);
    seqIn.downDone <= 1'h0;
    // key still high: fail-safe pass-through, deep off, then straight back up
    pwr();
    chk("fscount", 32'h1, {28'h0, rdVal[11:8]});
    chk("ststart", 32'h2, stStarts);
    $display("fault recovery done");
    pinsIn.powerKeyIn <= 1'h0;
    st(ST_PD_REQ);
    chk("downrun", 32'h1, {31'h0, seqOut.downRun});
    seqIn.downDone <= 1'h1;
    @(posedge clock);
    seqIn.downDone <= 1'h0;
    st(ST_DEEP_OFF);
    chk("hostrst", 32'h0, {31'h0, hostResetN});
    $display("turn off done");
    results();
  end
endmodule // test_pmic_power_state_machine
